// ===== osw_map.svh
`ifndef OSW_MAP_SVH
`define OSW_MAP_SVH
// Register byte offsets
`define OSW_MAIN_WAIT_OFF 8'h00
`define OSW_PLL_WAIT_OFF 8'h04
`define OSW_SUB_WAIT_OFF 8'h08
`define OSW_OSC_CTRL_OFF 8'h0c
`define OSW_STATUS_OFF 8'h10
`define OSW_PATTERN_OFF 8'h14
// Field positions
`define OSW_SEL_MSB 4
`define OSW_CTRL_MAIN_EN 0
`define OSW_CTRL_PLL_EN 1
`define OSW_CTRL_SUB_EN 2
// Reset values
`define OSW_MAIN_WAIT_RST 5'h00
`define OSW_PLL_WAIT_RST 5'h00
`define OSW_SUB_WAIT_RST 5'h00
`define OSW_PATTERN_RST 3'h1
// Fixed cycle counts added to the selected wait
`define OSW_MAIN_FIXED_CYC 32'd16384
`define OSW_PLL_FIXED_CYC 32'd131072
// Sub-clock offset, milliseconds, and hclk rate in kHz
`define OSW_SUB_OFFSET_MIN_MS 1800
`define OSW_SUB_OFFSET_MAX_MS 2600
`define OSW_HCLK_KHZ 20000
`endif

// ===== osw_pkg.sv
package osw_pkg;
  // Per-counter state
  typedef enum logic [1:0] {OSW_IDLE, OSW_SEL, OSW_FIX, OSW_DONE} osw_phase_t;
  // Bus slave state
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic act;
  } osw_bus_t;
endpackage

// ===== osw_wait_counter.sv
`timescale 1ns/1ps
`default_nettype none
// One wait: selected wait from a 5-bit code, then a fixed count; restarts on enable rise
module osw_wait_counter
#(
  parameter int CW = 40
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc_en,
  input wire logic tick,
  input wire logic [4:0] sel,
  input wire logic [CW-1:0] fixed_cycles,
  output logic stable
);
  import osw_pkg::*;
  // Whole state in one record
  typedef struct packed {
    osw_phase_t ph;
    logic [CW-1:0] cnt;
    logic en_prev;
    logic stable;
  } osw_wc_t;
  osw_wc_t s_q, s_d;
  // Selected wait grows as 2^(sel+1) ticks
  function automatic logic [CW-1:0] osw_sel_cycles(input logic [4:0] v);
    osw_sel_cycles = CW'(64'd2 << v);
  endfunction
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.en_prev = osc_en;
    if (!osc_en)
    begin
      s_d.ph = OSW_IDLE;
      s_d.stable = 1'b0;
    end
    else if (!s_q.en_prev)
    begin
      // Restart on every fresh enable
      s_d.ph = OSW_SEL; // [RULE16]
      s_d.cnt = osw_sel_cycles(sel);
      s_d.stable = 1'b0;
    end
    else if (tick)
    begin
      unique case (s_q.ph)
        OSW_IDLE: s_d.ph = OSW_IDLE;
        OSW_SEL:
        begin
          if (s_q.cnt <= CW'(1))
          begin
            s_d.ph = OSW_FIX; // [RULE1] [RULE4]
            s_d.cnt = fixed_cycles;
          end
          else
            s_d.cnt = s_q.cnt - CW'(1);
        end
        OSW_FIX:
        begin
          if (s_q.cnt <= CW'(1))
          begin
            // Stable only after both parts
            s_d.ph = OSW_DONE; // [RULE16]
            s_d.stable = 1'b1;
          end
          else
            s_d.cnt = s_q.cnt - CW'(1);
        end
        OSW_DONE: s_d.stable = 1'b1;
      endcase
    end
  end
  // Register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= '{ph: OSW_IDLE, cnt: '0, en_prev: 1'b0, stable: 1'b0};
    else
      s_q <= s_d;
  end
  assign stable = s_q.stable;
endmodule // osw_wait_counter
`default_nettype wire

// ===== osw_top.sv
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "osw_map.svh"
// What this block and its software must do
// [RULE1] Main wait: selected wait plus 16384 cycles
// [RULE2] Software picks main wait above resonator start-up
// [RULE3] Software waits start-up plus whole main wait
// [RULE4] PLL wait: selected wait plus 131072 cycles
// [RULE5] Software picks PLL wait above lock time
// [RULE6] PLL enabled only after main clock stable; pll_osc_en follows its control bit alone, not gated by main_stable
// [RULE7] Software waits lock time plus PLL wait
// [RULE8] Non-64-pin parts add 1.8-2.6 s offset
// [RULE9] Sub wait at least start-up minus offset
// [RULE10] Software waits max(start-up, offset) plus wait
// [RULE11] 64-pin parts: sub wait has no offset
// [RULE12] 64-pin software waits start-up plus wait
// [RULE13] Software picks pattern A-E; 48-pin uses A
// [RULE14] A/B: no crystal; C-E use crystal
// [RULE15] Peripheral clock B not below RTC source
// [RULE16] Counters restart on enable, flag after full wait
module osw_top
#(
  parameter bit PINS_64 = 1'b0,
  parameter int SUB_OFFSET_MS = `OSW_SUB_OFFSET_MAX_MS,
  parameter int unsigned SUB_OFFSET_CYC = SUB_OFFSET_MS * `OSW_HCLK_KHZ,
  parameter int MAIN_FIXED = `OSW_MAIN_FIXED_CYC,
  parameter int PLL_FIXED = `OSW_PLL_FIXED_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic main_tick,
  input wire logic pll_tick,
  input wire logic sub_tick,
  output logic main_stable,
  output logic pll_stable,
  output logic sub_stable,
  output logic main_osc_en,
  output logic pll_osc_en,
  output logic sub_osc_en
);
  import osw_pkg::*;
  // Ticks come from foreign oscillator domains, so they are synchronised and edge-detected
  typedef struct packed {
    osw_bus_t bus;
    logic [4:0] main_sel;
    logic [4:0] pll_sel;
    logic [4:0] sub_sel;
    logic [2:0] ctrl;
    logic [2:0] pattern;
    logic [31:0] rdata;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] stab;
    logic sub_sel_done; // Sub selected phase finished
    logic [39:0] sub_sel_cnt; // Sub tick edges seen since enable, up to the end of the selected phase
  } osw_top_t;
  osw_top_t s_q, s_d;
  logic [2:0] tick_edge;
  logic main_st, pll_st, sub_st;
  // Read word of any register as software sees it
  function automatic logic [31:0] osw_read(input osw_top_t s, input logic [7:0] a);
    unique case (a)
      `OSW_MAIN_WAIT_OFF: osw_read = {27'h0, s.main_sel};
      `OSW_PLL_WAIT_OFF: osw_read = {27'h0, s.pll_sel};
      `OSW_SUB_WAIT_OFF: osw_read = {27'h0, s.sub_sel};
      `OSW_OSC_CTRL_OFF: osw_read = {29'h0, s.ctrl};
      `OSW_STATUS_OFF: osw_read = {29'h0, s.stab};
      `OSW_PATTERN_OFF: osw_read = {29'h0, s.pattern};
      default: osw_read = 32'h0;
    endcase
  endfunction
  // Rising edges of synchronised ticks; first stage never read here
  assign tick_edge = s_q.sync2 & ~s_q.sync3;
  // Main counter
  osw_wait_counter #(.CW(40)) u_main (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_en(s_q.ctrl[`OSW_CTRL_MAIN_EN]),
    .tick(tick_edge[0]),
    .sel(s_q.main_sel),
    .fixed_cycles(40'(MAIN_FIXED)), // [RULE1]
    .stable(main_st)
  );
  // PLL counter
  osw_wait_counter #(.CW(40)) u_pll (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_en(s_q.ctrl[`OSW_CTRL_PLL_EN]),
    .tick(tick_edge[1]),
    .sel(s_q.pll_sel),
    .fixed_cycles(40'(PLL_FIXED)), // [RULE4]
    .stable(pll_st)
  );
  // Sub counter: offset counted in hclk cycles, so tick becomes 1 in fixed phase
  logic sub_tick_mux;
  // Offset phase counts hclk; selected phase counts sub ticks (offset is added after)
  osw_wait_counter #(.CW(40)) u_sub (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_en(s_q.ctrl[`OSW_CTRL_SUB_EN]),
    .tick(sub_tick_mux),
    .sel(s_q.sub_sel),
    .fixed_cycles(PINS_64 ? 40'd1 : 40'(SUB_OFFSET_CYC)), // [RULE8] [RULE11]
    .stable(sub_st)
  );
  // Tick source switch: once the selected wait is done, offset runs on hclk
  // 64-pin: no offset, the single fixed cycle is negligible
  assign sub_tick_mux = s_q.sub_sel_done ? 1'b1 : tick_edge[2]; // [RULE8]
  // Next state: bus and registers
  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = {sub_tick, pll_tick, main_tick};
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.stab = {sub_st, pll_st, main_st}; // [RULE16]
    // Mirror of the sub counter's selected phase; a disabled oscillator starts over
    if (!s_q.ctrl[`OSW_CTRL_SUB_EN])
    begin
      s_d.sub_sel_done = 1'b0;
      s_d.sub_sel_cnt = 40'h0;
    end
    else if (!s_q.sub_sel_done && tick_edge[2])
    begin
      // Same length as the counter's selected phase
      s_d.sub_sel_cnt = s_q.sub_sel_cnt + 40'd1;
      if (s_q.sub_sel_cnt + 40'd1 >= (40'd2 << s_q.sub_sel))
        s_d.sub_sel_done = 1'b1;
    end
    // Data phase write
    if (s_q.bus.act && s_q.bus.wr)
    begin
      unique case (s_q.bus.addr)
        `OSW_MAIN_WAIT_OFF: s_d.main_sel = hwdata[`OSW_SEL_MSB:0];
        `OSW_PLL_WAIT_OFF: s_d.pll_sel = hwdata[`OSW_SEL_MSB:0];
        `OSW_SUB_WAIT_OFF: s_d.sub_sel = hwdata[`OSW_SEL_MSB:0];
        `OSW_OSC_CTRL_OFF: s_d.ctrl = hwdata[2:0];
        // Pattern is software's bookkeeping; values other than 1..5 are kept as written
        `OSW_PATTERN_OFF: s_d.pattern = hwdata[2:0]; // [RULE13]
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    // Address phase capture
    s_d.bus.act = hsel && hready && htrans[1];
    s_d.bus.addr = haddr;
    s_d.bus.wr = hwrite;
    // Read data prepared a cycle ahead so it comes from a flip-flop
    s_d.rdata = osw_read(s_q, haddr);
  end
  // Register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.pattern <= `OSW_PATTERN_RST;
    end
    else
      s_q <= s_d;
  end
  // Outputs from flip-flops; hreadyout and hresp are constants
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign main_stable = s_q.stab[0]; // [RULE1]
  assign pll_stable = s_q.stab[1]; // [RULE4]
  assign sub_stable = s_q.stab[2];
  assign main_osc_en = s_q.ctrl[`OSW_CTRL_MAIN_EN];
  assign pll_osc_en = s_q.ctrl[`OSW_CTRL_PLL_EN];
  assign sub_osc_en = s_q.ctrl[`OSW_CTRL_SUB_EN];
endmodule // osw_top
`default_nettype wire

// ===== osw_checker.sv
`timescale 1ns/1ps
`default_nettype none
module osw_checker
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic main_stable,
  input wire logic pll_stable,
  input wire logic sub_stable,
  input wire logic main_osc_en,
  input wire logic pll_osc_en,
  input wire logic sub_osc_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Zero-wait slave, never an error
  a_bus_always_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  // Fixed counts alone outlast eight cycles, except the single sub cycle on 64-pin parts
  a_main_not_early: assert property ($rose(main_osc_en) |=> !main_stable [*8]) else $error("main early");
  a_pll_not_early: assert property ($rose(pll_osc_en) |=> !pll_stable [*8]) else $error("pll early");
  a_sub_not_early: assert property ($rose(sub_osc_en) |=> !sub_stable [*8]) else $error("sub early");
  // Main flag may only rise if main was enabled eight cycles earlier
  a_main_rise_cause: assert property ($rose(main_stable) |-> $past(main_osc_en, 8)) else $error("main rose");
  // Disabling drops the flag soon
  a_main_drop_off: assert property ($fell(main_osc_en) |-> ##[0:4] !main_stable) else $error("main held");
  a_pll_drop_off: assert property ($fell(pll_osc_en) |-> ##[0:4] !pll_stable) else $error("pll held");
  cover property ($rose(main_stable));
  cover property ($rose(pll_stable));
  cover property ($rose(sub_stable));
endmodule // osw_checker
`default_nettype wire

// ===== osw_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Resonator: toggles only while enabled, stands at 0 otherwise
module osw_osc_model
#(
  parameter int HALF = 2
)
(
  input wire logic hclk,
  input wire logic en,
  output var logic tick
);
  int cnt = 0;
  initial tick = 1'b0;
  // Half period counted in hclk cycles
  always @(posedge hclk)
  begin
    if (en !== 1'b1)
    begin
      tick <= 1'b0;
      cnt <= 0;
    end
    else if (cnt == HALF - 1)
    begin
      tick <= ~tick;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // osw_osc_model
`default_nettype wire

// ===== test_oscillator_stabilization_wait.sv
`timescale 1ns/1ps
`default_nettype none
module test_oscillator_stabilization_wait;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 0, hrdata, rd;
  logic main_tick, pll_tick, sub_tick, main_stable, pll_stable, sub_stable, main_osc_en, pll_osc_en, sub_osc_en;
  int errors = 0, comparisons = 0, cyc = 0;
  always #25 hclk = ~hclk;
  // Oscillators of three different periods
  osw_osc_model u_main (.hclk(hclk), .en(main_osc_en), .tick(main_tick));
  osw_osc_model #(.HALF(3)) u_pll (.hclk(hclk), .en(pll_osc_en), .tick(pll_tick));
  osw_osc_model #(.HALF(5)) u_sub (.hclk(hclk), .en(sub_osc_en), .tick(sub_tick));
  // Shortened fixed counts keep the run brief
  osw_top #(.SUB_OFFSET_CYC(100), .MAIN_FIXED(16), .PLL_FIXED(16)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .main_tick(main_tick),
    .pll_tick(pll_tick), .sub_tick(sub_tick), .main_stable(main_stable), .pll_stable(pll_stable),
    .sub_stable(sub_stable), .main_osc_en(main_osc_en), .pll_osc_en(pll_osc_en), .sub_osc_en(sub_osc_en));
  // One single AHB transfer, entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycles from enable until a flag rises must fall in a window
  task automatic wait_up(input int idx, input int lo, input int hi);
    int n;
    logic [2:0] st;
    n = 0;
    st = 3'h0;
    while (st[idx] !== 1'b1 && n < 400)
    begin
      @(posedge hclk);
      n++;
      st = {sub_stable, pll_stable, main_stable};
    end
    chk(n, (n < lo || n > hi) ? lo : n);
  endtask
  task automatic wrap_up();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, 8'h14, 0);
    chk(rd, 32'h1);
    ahb(0, 8'h10, 0);
    chk(rd, 32'h0);
    // Unmapped place ignores writes and reads zero
    ahb(1, 8'h18, 32'hffffffff);
    ahb(0, 8'h18, 0);
    chk(rd, 32'h0);
    for (int p = 1; p <= 5; p++)
    begin
      ahb(1, 8'h14, p);
      ahb(0, 8'h14, 0);
      chk(rd, p);
    end
    ahb(1, 8'h04, 32'h1);
    ahb(0, 8'h04, 0);
    chk(rd, 32'h1);
    // Main: 2 + 16 ticks of 4 cycles
    ahb(1, 8'h0c, 32'h1);
    wait_up(0, 66, 84);
    ahb(0, 8'h10, 0);
    chk(rd, 32'h1);
    // Pll only after main is stable: 4 + 16 ticks of 6 cycles
    ahb(1, 8'h0c, 32'h3);
    wait_up(1, 114, 132);
    // Sub wait field programmed before the oscillator starts
    ahb(1, 8'h08, 32'h1);
    ahb(0, 8'h08, 0);
    chk(rd, 32'h1);
    // Sub: 4 ticks of 10 cycles plus offset of 100
    ahb(1, 8'h0c, 32'h7);
    wait_up(2, 132, 160);
    ahb(0, 8'h10, 0);
    chk(rd, 32'h7);
    // Disable main, pick a longer wait, restart: 8 + 16 ticks
    ahb(1, 8'h0c, 32'h6);
    ahb(1, 8'h00, 32'h2);
    // Flag drops two edges after the write lands; look once it has settled
    @(posedge hclk);
    chk({31'h0, main_stable}, 32'h0);
    ahb(1, 8'h0c, 32'h7);
    wait_up(0, 90, 108);
    wrap_up();
  end
endmodule // test_oscillator_stabilization_wait
bind osw_top osw_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .main_stable(main_stable), .pll_stable(pll_stable), .sub_stable(sub_stable), .main_osc_en(main_osc_en),
  .pll_osc_en(pll_osc_en), .sub_osc_en(sub_osc_en));
`default_nettype wire
